// ==== logic/dsarr_pkg.sv ====
// Purpose: Shared constants for the differential converter serial readout ends.
// Assumes: One 20 MHz system clock at both ends; the host makes the serial clock by division.
// Notes: The converter end models the digital sequencing; the analog value arrives as a word.
// How it works
// - Full conversion spans sixteen serial clock cycles.
// - Host may stop early at fourteen or fifteen.
// - Device shifts each bit on falling edges.
// - Host may capture on falling edges instead.
// - Select fall starts conversion and transfer.
// - Input sampled until second falling edge.
// - Output driver enabled at second falling edge.
// - Null bit first, top bit at third.
// - Twelve result bits follow, top bit first.
// - Select still low: resend from bit one upward.
// - After resent bit eleven output floats.
// - Select raised by fifteenth fall: no resend.
// - Later clocks while select low do nothing.
// - New conversion needs select high then low.
// - Results are twelve-bit two's complement codes.
// - Saturate at 7FF and 800 codes.
// - One step is twice reference over 4096.
// - Power down at select rise or fall 14/16.
// - Host drops select only while clock low.
package dsarr_pkg;
    localparam int RES_BITS = 12;
    localparam int FALL_W = 5;
    localparam logic [FALL_W-1:0] FALL_ENABLE = 5'h02;
    localparam logic [FALL_W-1:0] FALL_TOP_BIT = 5'h03;
    localparam logic [FALL_W-1:0] FALL_BIT_ZERO = 5'h0E;
    localparam logic [FALL_W-1:0] FALL_SHORT_PD = 5'h0E;
    localparam logic [FALL_W-1:0] FALL_NO_RESEND = 5'h0F;
    localparam logic [FALL_W-1:0] FALL_FULL_PD = 5'h10;
    localparam logic [FALL_W-1:0] FALL_RESEND_END = 5'h19;
    localparam logic [FALL_W-1:0] FALL_LAST = 5'h1A;
    localparam logic [FALL_W-1:0] FALLS_FULL = 5'h10;
    localparam logic [RES_BITS-1:0] CODE_POS_FULL = 12'h7FF;
    localparam logic [RES_BITS-1:0] CODE_NEG_FULL = 12'h800;
    localparam int CODE_STEPS = 4096;
    // The half period must outlast the round trip through both synchronisers and the output register.
    // Otherwise a bit changes just as the host samples it on the rising edge.
    localparam int SCLK_HALF_NS = 400;
    localparam int SYS_CLK_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int HALF_W = 4;
    localparam int SAMPLE_W = 14;
    typedef enum logic [1:0] {DSARR_IDLE, DSARR_LOW, DSARR_CLK_HI, DSARR_END} dsarr_host_st_t;

    // Clamp a signed sample held in steps of twice the reference over 4096.
    function automatic logic [RES_BITS-1:0] dsarr_clamp(input logic signed [SAMPLE_W-1:0] s);
        if (s >= $signed({2'b00, CODE_POS_FULL})) begin
            dsarr_clamp = CODE_POS_FULL;
        end else if (s <= $signed({2'b11, CODE_NEG_FULL})) begin
            dsarr_clamp = CODE_NEG_FULL;
        end else begin
            dsarr_clamp = s[RES_BITS-1:0];
        end
    endfunction : dsarr_clamp
endpackage : dsarr_pkg

// ==== logic/dsarr_link_if.sv ====
// Purpose: Three-wire link between host and converter.
// Assumes: The converter output enable is low while it drives.
// Notes: dout_line resolves the tri-state data pin; it floats high when undriven.
`timescale 1ns/1ps
interface dsarr_link_if;
    logic sel_n;
    logic sclk;
    logic dout_o;
    logic dout_oe_n;
    wire dout_line;
    assign dout_line = dout_oe_n ? 1'b1 : dout_o;
    modport conv(input sel_n, input sclk, output dout_o, output dout_oe_n);
    modport host(output sel_n, output sclk, input dout_line);
endinterface : dsarr_link_if

// ==== logic/dsarr_conv.sv ====
// Purpose: Converter end: sequencing and serial result output.
// Assumes: Select and serial clock come from another party and are resynchronised.
// Notes: The analog difference arrives as a signed step count on sample_in.
`timescale 1ns/1ps
module dsarr_conv (
    input wire logic clk,
    input wire logic reset,
    dsarr_link_if.conv link,
    input wire logic signed [dsarr_pkg::SAMPLE_W-1:0] sample_in,
    output logic powered_down,
    output logic [dsarr_pkg::RES_BITS-1:0] held_code
);
    import dsarr_pkg::*;

    // =====================================================================
    // Pin synchronisers
    logic [2:0] sel_s_r;
    logic [2:0] sclk_s_r;
    logic sel_q_r;
    logic sclk_q_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_s_r <= 3'h7;
            sclk_s_r <= 3'h0;
            sel_q_r <= 1'b1;
            sclk_q_r <= 1'b0;
        end else begin
            sel_s_r <= {sel_s_r[1:0], link.sel_n};
            sclk_s_r <= {sclk_s_r[1:0], link.sclk};
            if (sel_s_r[1] == sel_s_r[2]) begin
                sel_q_r <= sel_s_r[2];
            end
            if (sclk_s_r[1] == sclk_s_r[2]) begin
                sclk_q_r <= sclk_s_r[2];
            end
        end
    end
    wire sel_agree = (sel_s_r[1] == sel_s_r[2]);
    wire sclk_agree = (sclk_s_r[1] == sclk_s_r[2]);
    wire sel_fall = sel_agree && sel_q_r && !sel_s_r[2];
    wire sel_rise = sel_agree && !sel_q_r && sel_s_r[2];
    wire sclk_fall = sclk_agree && sclk_q_r && !sclk_s_r[2];
    wire sel_low = !sel_q_r;

    // =====================================================================
    // Sequence
    logic active_r;
    logic resend_ok_r;
    logic [FALL_W-1:0] fall_r;
    logic [RES_BITS-1:0] code_r;
    logic dout_r;
    logic oe_n_r;
    logic pd_r;
    wire [FALL_W-1:0] fall_nxt = fall_r + 5'h01;
    wire counting = active_r && sel_low && !sel_fall && sclk_fall;
    // Bit index shown at a given fall: top bit first, then bit one upward.
    wire [3:0] fwd_idx = 4'(FALL_BIT_ZERO - fall_nxt);
    wire [3:0] rev_idx = 4'(fall_nxt - FALL_BIT_ZERO);
    wire in_fwd = (fall_nxt >= FALL_TOP_BIT) && (fall_nxt <= FALL_BIT_ZERO);
    wire in_rev = (fall_nxt > FALL_BIT_ZERO) && (fall_nxt <= FALL_RESEND_END);
    wire pd_edge = (fall_nxt == FALL_SHORT_PD) || (fall_nxt == FALL_FULL_PD);
    wire in_sample = (fall_nxt < FALL_ENABLE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_r <= 1'b0;
            resend_ok_r <= 1'b0;
            fall_r <= '0;
            code_r <= '0;
            dout_r <= 1'b0;
            oe_n_r <= 1'b1;
            pd_r <= 1'b1;
        end else if (sel_fall) begin
            active_r <= 1'b1;
            resend_ok_r <= 1'b1;
            fall_r <= '0;
            oe_n_r <= 1'b1;
            pd_r <= 1'b0;
        end else if (sel_rise || !sel_low) begin
            active_r <= 1'b0;
            oe_n_r <= 1'b1;
            pd_r <= 1'b1;
            if (sel_rise && fall_r <= FALL_NO_RESEND) begin
                resend_ok_r <= 1'b0;
            end
        end else if (counting) begin
            fall_r <= fall_nxt;
            if (fall_nxt == FALL_ENABLE) begin
                code_r <= dsarr_clamp(sample_in);
                oe_n_r <= 1'b0;
                dout_r <= 1'b0;
            end else if (in_fwd) begin
                dout_r <= code_r[fwd_idx];
            end else if (in_rev && resend_ok_r) begin
                dout_r <= code_r[rev_idx];
            end else if (!in_sample) begin
                // The first fall still lies inside the sampling window and must not close the frame.
                oe_n_r <= 1'b1;
                active_r <= 1'b0;
            end
            if (pd_edge) begin
                pd_r <= 1'b1;
            end
        end
    end

    assign link.dout_o = dout_r;
    assign link.dout_oe_n = oe_n_r;
    assign powered_down = pd_r;
    assign held_code = code_r;
endmodule : dsarr_conv

// ==== logic/dsarr_host.sv ====
// Purpose: Host end: drives select and serial clock, gathers the result.
// Assumes: Same system clock as the converter; the serial clock is a divided copy.
// Notes: Captures on rising serial clock edges, the usual choice.
`timescale 1ns/1ps
module dsarr_host (
    input wire logic clk,
    input wire logic reset,
    dsarr_link_if.host link,
    input wire logic start,
    input wire logic [dsarr_pkg::FALL_W-1:0] fall_count,
    output logic busy,
    output logic done,
    output logic [dsarr_pkg::RES_BITS-1:0] result,
    output logic [dsarr_pkg::RES_BITS-1:0] resend
);
    import dsarr_pkg::*;

    // =====================================================================
    // Serial clock divider and frame control
    dsarr_host_st_t st_r;
    logic [HALF_W-1:0] div_r;
    logic [FALL_W-1:0] falls_r;
    logic [FALL_W-1:0] limit_r;
    logic [RES_BITS-1:0] res_r;
    logic [RES_BITS-1:0] rev_r;
    logic done_r;
    logic [2:0] din_s_r;
    wire tick = (div_r == HALF_W'(SCLK_HALF_CYC - 1));
    wire [FALL_W-1:0] falls_nxt = falls_r + 5'h01;
    wire din = din_s_r[2];
    wire take_fwd = (falls_r >= FALL_TOP_BIT) && (falls_r <= FALL_BIT_ZERO);
    wire take_rev = (falls_r > FALL_BIT_ZERO) && (falls_r <= FALL_RESEND_END);
    // The end phase samples where the next rise would come, so a fourteen-fall frame still keeps bit zero.
    wire capture = tick && (st_r == DSARR_LOW || st_r == DSARR_END);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            din_s_r <= 3'h0;
        end else begin
            din_s_r <= {din_s_r[1:0], link.dout_line};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_r <= '0;
            rev_r <= '0;
        end else if (capture && take_fwd) begin
            res_r <= {res_r[RES_BITS-2:0], din};
        end else if (capture && take_rev) begin
            rev_r <= {din, rev_r[RES_BITS-1:1]};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= DSARR_IDLE;
            div_r <= '0;
            falls_r <= '0;
            limit_r <= FALLS_FULL;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            div_r <= (st_r == DSARR_IDLE || tick) ? '0 : div_r + 4'h1;
            unique case (st_r)
                DSARR_IDLE: begin
                    if (start) begin
                        // Clock is low while select falls.
                        st_r <= DSARR_LOW;
                        falls_r <= '0;
                        limit_r <= (fall_count < FALL_SHORT_PD) ? FALLS_FULL : fall_count;
                    end
                end
                DSARR_LOW: begin
                    if (tick) begin
                        st_r <= DSARR_CLK_HI;
                    end
                end
                DSARR_CLK_HI: begin
                    if (tick) begin
                        falls_r <= falls_nxt;
                        st_r <= (falls_nxt >= limit_r) ? DSARR_END : DSARR_LOW;
                    end
                end
                DSARR_END: begin
                    if (tick) begin
                        st_r <= DSARR_IDLE;
                        done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign link.sel_n = (st_r == DSARR_IDLE);
    assign link.sclk = (st_r == DSARR_CLK_HI);
    assign busy = (st_r != DSARR_IDLE);
    assign done = done_r;
    assign result = res_r;
    assign resend = {rev_r[RES_BITS-1:1], res_r[0]};
endmodule : dsarr_host

// ==== verif/dsarr_link_checker.sv ====
// Purpose: Wire checks on the three-wire link.
// Assumes: Host frames end within 26 serial clock falls.
// Notes: Falls are counted one clock after the wire shows them.
`timescale 1ns/1ps
module dsarr_link_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic dout_o,
    input wire logic dout_oe_n,
    input wire logic dout_line
);
    logic sclk_r;
    logic [4:0] falls_r;
    logic [3:0] since_r;
    wire fall_now = sclk_r && !sclk;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_r <= 1'b0;
            falls_r <= 5'h00;
            since_r <= 4'hF;
        end else begin
            sclk_r <= sclk;
            falls_r <= sel_n ? 5'h00 : falls_r + {4'h0, fall_now && falls_r != 5'h1F};
            since_r <= fall_now ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_IDLE_FLOAT: assert property (sel_n [*6] |-> dout_oe_n) else $error("driven while idle");
    AST_CLK_STILL: assert property (sel_n |-> !sclk) else $error("clock outside frame");
    AST_NO_EARLY_EN: assert property (!sel_n && !dout_oe_n |-> falls_r >= 5'h02) else $error("early enable");
    AST_EN_SECOND: assert property (fall_now && falls_r == 5'h01 && !sel_n |-> ##[1:6] !dout_oe_n)
        else $error("no enable");
    AST_NULL_FIRST: assert property ($fell(dout_oe_n) |-> !dout_o) else $error("null bit not 0");
    AST_RESEND_END: assert property (fall_now && falls_r == 5'h19 && !sel_n |-> ##[1:6] dout_oe_n)
        else $error("no float at end");
    AST_SHORT_FLOAT: assert property ($rose(sel_n) |-> ##[1:6] dout_oe_n) else $error("no float");
    AST_ON_FALL: assert property ($changed(dout_o) && !dout_oe_n |-> since_r <= 4'h5) else $error("bad shift");
    AST_MIN_FALLS: assert property ($rose(sel_n) |-> $past(falls_r) >= 5'h0E) else $error("short frame");
    AST_SEL_CLK_LOW: assert property ($fell(sel_n) |-> !sclk) else $error("select fell high");
endmodule : dsarr_link_checker

// ==== verif/dsarr_tb.sv ====
// Purpose: Self-checking bench of host and converter ends.
// Assumes: Select idles at least ten clocks between frames.
// Notes: A monitor rebuilds each frame from rising and from falling serial clock edges.
`timescale 1ns/1ps
module dsarr_tb;
    import dsarr_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [FALL_W-1:0] fall_count = 5'h10;
    logic signed [SAMPLE_W-1:0] sample_in = 14'h0000;
    logic busy, done, powered_down;
    logic [RES_BITS-1:0] result, resend, held_code;
    logic [31:0] mon_w = 32'h0;
    logic [31:0] mon_f = 32'h0;
    logic sclk_seen = 1'b0;
    logic [31:0] seed = 32'h6626;
    logic [13:0] corner [6] = '{14'h0000, 14'h3FFF, 14'h07FF, 14'h0BB8, 14'h3800, 14'h2000};
    logic [4:0] fcs [5] = '{5'h0E, 5'h0F, 5'h10, 5'h1A, 5'h00};
    int err_count = 0;
    int checks_done = 0;
    dsarr_link_if link_i ();
    dsarr_conv dsarr_conv_i (.clk(clk), .reset(reset), .link(link_i.conv), .sample_in(sample_in),
        .powered_down(powered_down), .held_code(held_code));
    dsarr_host dsarr_host_i (.clk(clk), .reset(reset), .link(link_i.host), .start(start), .fall_count(fall_count),
        .busy(busy), .done(done), .result(result), .resend(resend));
    dsarr_link_checker dsarr_link_checker_i (.clk(clk), .reset(reset), .sel_n(link_i.sel_n), .sclk(link_i.sclk),
        .dout_o(link_i.dout_o), .dout_oe_n(link_i.dout_oe_n), .dout_line(link_i.dout_line));
    always #25 clk = ~clk;
    // One block writes both shift registers; a wake-up with no serial clock change is the select fall.
    always @(negedge link_i.sel_n or link_i.sclk) begin
        if (link_i.sclk === sclk_seen) begin
            mon_w = 32'h0;
            mon_f = 32'h0;
        end else if (!link_i.sel_n && link_i.sclk) begin
            mon_w = {mon_w[30:0], link_i.dout_line};
        end else if (!link_i.sel_n) begin
            mon_f = {mon_f[30:0], link_i.dout_line};
        end
        sclk_seen = link_i.sclk;
    end
    // =====================================================
    // Expectations and checks
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [11:0] exp_code(input logic signed [13:0] s);
        if (s >= 2047) return 12'h7FF;
        if (s <= -2048) return 12'h800;
        return s[11:0];
    endfunction : exp_code
    // Rise k captures what fall k-1 put out: float, null, top bit first, then the resend.
    function automatic logic [31:0] exp_wire(input logic [11:0] c, input int n);
        logic [31:0] w;
        w = 32'h0;
        for (int k = 1; k <= n; k++) w = {w[30:0], (k < 3) ? 1'b1 : (k == 3) ? 1'b0 : (k < 16) ? c[15-k] : c[k-15]};
        return w;
    endfunction : exp_wire
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic frame(input logic [13:0] s, input logic [4:0] n);
        int w;
        logic [11:0] c;
        w = 0;
        c = exp_code(s);
        @(negedge clk);
        sample_in = s;
        fall_count = n;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk("busy", busy, 1);
        repeat (8) @(negedge clk);
        chk("powered_up", powered_down, 0);
        while (done !== 1'b1 && w < 500) begin
            @(negedge clk);
            w++;
        end
        chk("done", w < 500, 1);
        chk("busy_end", busy, 0);
        chk("result", result, c);
        chk("held_code", held_code, c);
        chk("wire", mon_w, exp_wire(c, (n < 5'h0E) ? 16 : n));
        chk("wire_fall", mon_f, exp_wire(c, (n < 5'h0E) ? 16 : n));
        if (n == 5'h1A) chk("resend", resend, c);
        repeat (6) @(negedge clk);
        chk("powered_down", powered_down, 1);
        chk("float", link_i.dout_line, 1);
        repeat (6) @(negedge clk);
    endtask : frame
    // =====================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        foreach (corner[i]) frame(corner[i], fcs[i % 5]);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            frame(seed[13:0], fcs[i % 5]);
        end
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (40) @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        chk("reset_sel", link_i.sel_n, 1);
        chk("reset_float", link_i.dout_line, 1);
        reset = 1'b0;
        repeat (8) @(negedge clk);
        frame(14'h0123, 5'h1A);
        close_out();
    end
    initial begin
        #1000000;
        err_count++;
        close_out();
    end
endmodule : dsarr_tb
